// >>> design/pif_pkg.sv
// constants and types for the per-port ingress admission filter
package pif_pkg;
    localparam int NUM_PORTS = 10;
    localparam int CPU_PORT = 8;
    localparam int NUM_RATE_PORTS = 8;
    localparam int PORT_W = 4;
    localparam int ADDR_W = 8;
    // indirect addresses: port n link control at 2n, filter control at 2n+1
    localparam logic [ADDR_W-1:0] LINK_CTRL_BASE = 8'h00;
    localparam logic [ADDR_W-1:0] FILT_CTRL_BASE = 8'h01;
    localparam logic [7:0] LINK_CTRL_RST = 8'hc0;
    localparam logic [7:0] FILT_CTRL_RST = 8'h00;
    // link control fields
    localparam int LC_FC_DIS = 0;
    localparam int LC_DUPLEX = 1;
    localparam int LC_SPEED10 = 2;
    localparam int LC_LINK_UP = 3;
    localparam int LC_MUST1 = 4;
    localparam int LC_ASYM = 5;
    localparam int LC_SS_LO = 6;
    localparam int LC_SS_HI = 7;
    // filter control fields
    localparam int FC_UNTAG = 0;
    localparam int FC_TAG = 1;
    localparam int FC_LEARN_DIS = 2;
    localparam int FC_RATE_SEL = 3;
    localparam int FC_SEC_LO = 6;
    localparam int FC_SEC_HI = 7;
    localparam logic [1:0] SEC_OFF = 2'h0;
    localparam logic [1:0] SEC_DISCARD = 2'h1;
    localparam logic [1:0] SEC_COPY_CPU = 2'h2;
    localparam logic [1:0] SEC_CPU_ONLY = 2'h3;
    // rate refresh timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int RATE_FAST_NS = 10000;
    localparam int RATE_SLOW_NS = 1000000;
    localparam int RATE_FAST_CYC = RATE_FAST_NS / CLK_PERIOD_NS;
    localparam int RATE_SLOW_CYC = RATE_SLOW_NS / CLK_PERIOD_NS;
    localparam int RATE_CNT_W = 16;
    typedef enum logic [1:0] {PIF_IDLE, PIF_LOOKUP, PIF_DONE} pif_state_t;
endpackage

// >>> design/pif_rate_tick.sv
// refresh tick generator for one reduced-mii port's rate control
`timescale 1ns/100ps
`default_nettype none
module pif_rate_tick #(
    parameter int SLOW_CYC = pif_pkg::RATE_SLOW_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic slow_sel_i,
    output logic tick_o
);
    localparam logic [pif_pkg::RATE_CNT_W-1:0] FAST_LAST =
        pif_pkg::RATE_CNT_W'(pif_pkg::RATE_FAST_CYC - 1);
    localparam logic [pif_pkg::RATE_CNT_W-1:0] SLOW_LAST =
        pif_pkg::RATE_CNT_W'(SLOW_CYC - 1);

    logic [pif_pkg::RATE_CNT_W-1:0] cnt;
    logic [pif_pkg::RATE_CNT_W-1:0] next_cnt;
    logic next_tick;
    logic [pif_pkg::RATE_CNT_W-1:0] last;

    always_comb
    begin
        last = slow_sel_i ? SLOW_LAST : FAST_LAST;
        // a select change mid-period takes effect at once; cnt past last wraps
        if (cnt >= last)
        begin
            next_cnt = '0;
            next_tick = 1'b1;
        end
        else
        begin
            next_cnt = cnt + 1'b1;
            next_tick = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            cnt <= '0;
            tick_o <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            tick_o <= next_tick;
        end
    end

    // check helper: cycles since the last tick, and whether the select
    // stayed on the fast rate all that time (a long delay would choke tools)
    localparam logic [pif_pkg::RATE_CNT_W-1:0] FAST_GAP =
        pif_pkg::RATE_CNT_W'(pif_pkg::RATE_FAST_CYC);
    logic [pif_pkg::RATE_CNT_W-1:0] gap;
    logic [pif_pkg::RATE_CNT_W-1:0] next_gap;
    logic fast_run;
    logic next_fast_run;

    always_comb
    begin
        next_gap = gap;
        if (tick_o)
            next_gap = pif_pkg::RATE_CNT_W'(1);
        else if (gap != '1)
            next_gap = gap + 1'b1;
        next_fast_run = !slow_sel_i && (tick_o || fast_run);
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            gap <= '0;
            fast_run <= 1'b0;
        end
        else
        begin
            gap <= next_gap;
            fast_run <= next_fast_run;
        end
    end

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    a_tick_fast_period: assert property (
        tick_o && fast_run |-> gap == FAST_GAP)
        else $error("fast refresh tick not at 10 us spacing");
    a_tick_not_late: assert property (
        fast_run && !tick_o |-> gap < FAST_GAP)
        else $error("fast refresh tick overdue");
endmodule
`default_nettype wire

// >>> design/pif_ingress_filter.sv
// per-port ingress admission: spanning state, filters, port security, cpu link
`timescale 1ns/100ps
`default_nettype none
module pif_ingress_filter #(
    parameter int RATE_SLOW_CYC = pif_pkg::RATE_SLOW_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // indirect register access from cpu or i2c master
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [pif_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // cpu port interface configuration
    input wire logic cpu_serial_mii_i,
    output logic cpu_link_up_o,
    output logic cpu_speed_10_o,
    output logic cpu_fc_en_o,
    output logic cpu_pause_tx_en_o,
    output logic cpu_pause_rx_en_o,
    // received frame from a port mac
    input wire logic frm_valid_i,
    input wire logic [pif_pkg::PORT_W-1:0] frm_port_i,
    input wire logic frm_tagged_i,
    input wire logic frm_sa_filt_i,
    input wire logic frm_da_filt_i,
    output logic frm_ready_o,
    // source address lookup
    output logic lk_req_o,
    input wire logic lk_valid_i,
    input wire logic lk_hit_i,
    input wire logic lk_static_i,
    input wire logic lk_addr_bit0_i,
    input wire logic [pif_pkg::PORT_W-1:0] lk_port_i,
    // forwarding decision
    output logic dec_valid_o,
    output logic [pif_pkg::PORT_W-1:0] dec_port_o,
    output logic dec_forward_o,
    output logic dec_to_cpu_o,
    output logic dec_learn_o,
    output logic dec_violation_o,
    // rate control refresh ticks for reduced-mii ports
    output logic [pif_pkg::NUM_RATE_PORTS-1:0] rate_tick_o
);
    // ---------------- register file ----------------
    logic [7:0] link_ctrl [pif_pkg::NUM_PORTS];
    logic [7:0] filt_ctrl [pif_pkg::NUM_PORTS];
    logic [7:0] next_link_ctrl [pif_pkg::NUM_PORTS];
    logic [7:0] next_filt_ctrl [pif_pkg::NUM_PORTS];
    logic [7:0] next_rdata;
    logic [6:0] reg_idx;
    logic reg_hit;

    always_comb
    begin
        reg_idx = reg_addr_i[pif_pkg::ADDR_W-1:1];
        reg_hit = 32'(reg_idx) < pif_pkg::NUM_PORTS;
        next_rdata = reg_rdata_o;
        for (int i = 0; i < pif_pkg::NUM_PORTS; i++)
        begin
            next_link_ctrl[i] = link_ctrl[i];
            next_filt_ctrl[i] = filt_ctrl[i];
        end
        if (reg_wr_i && reg_hit)
        begin
            if (reg_addr_i[0] == pif_pkg::FILT_CTRL_BASE[0])
                next_filt_ctrl[reg_idx[3:0]] = reg_wdata_i;
            else
                next_link_ctrl[reg_idx[3:0]] = reg_wdata_i;
        end
        // unmapped addresses read as zero
        if (reg_rd_i)
        begin
            if (!reg_hit)
                next_rdata = 8'h00;
            else if (reg_addr_i[0] == pif_pkg::FILT_CTRL_BASE[0])
                next_rdata = filt_ctrl[reg_idx[3:0]];
            else
                next_rdata = link_ctrl[reg_idx[3:0]];
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < pif_pkg::NUM_PORTS; i++)
            begin
                link_ctrl[i] <= pif_pkg::LINK_CTRL_RST;
                filt_ctrl[i] <= pif_pkg::FILT_CTRL_RST;
            end
            reg_rdata_o <= 8'h00;
        end
        else
        begin
            for (int i = 0; i < pif_pkg::NUM_PORTS; i++)
            begin
                link_ctrl[i] <= next_link_ctrl[i];
                filt_ctrl[i] <= next_filt_ctrl[i];
            end
            reg_rdata_o <= next_rdata;
        end
    end

    // ---------------- cpu port link configuration ----------------
    // duplex and bit 4 are the configuring party's duty; they are not
    // checked here so a bad write still brings the link up as programmed
    logic [7:0] cpu_lc;
    logic next_link_up;
    logic next_speed_10;
    logic next_fc_en;
    logic next_pause_tx;
    logic next_pause_rx;

    always_comb
    begin
        cpu_lc = link_ctrl[pif_pkg::CPU_PORT];
        // serial-only mode has no mii: link stays down, pause off
        next_link_up = cpu_serial_mii_i && cpu_lc[pif_pkg::LC_LINK_UP];
        next_speed_10 = cpu_lc[pif_pkg::LC_SPEED10];
        next_fc_en = next_link_up && !cpu_lc[pif_pkg::LC_FC_DIS];
        next_pause_tx = next_fc_en && !cpu_lc[pif_pkg::LC_ASYM];
        next_pause_rx = next_fc_en;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            cpu_link_up_o <= 1'b0;
            cpu_speed_10_o <= 1'b0;
            cpu_fc_en_o <= 1'b0;
            cpu_pause_tx_en_o <= 1'b0;
            cpu_pause_rx_en_o <= 1'b0;
        end
        else
        begin
            cpu_link_up_o <= next_link_up;
            cpu_speed_10_o <= next_speed_10;
            cpu_fc_en_o <= next_fc_en;
            cpu_pause_tx_en_o <= next_pause_tx;
            cpu_pause_rx_en_o <= next_pause_rx;
        end
    end

    // ---------------- rate refresh timers ----------------
    for (genvar g = 0; g < pif_pkg::NUM_RATE_PORTS; g++)
    begin : g_rate
        pif_rate_tick #(
            .SLOW_CYC(RATE_SLOW_CYC)
        ) u_tick (
            .sys_clk_i(sys_clk_i),
            .rst_i(rst_i),
            .slow_sel_i(filt_ctrl[g][pif_pkg::FC_RATE_SEL]),
            .tick_o(rate_tick_o[g])
        );
    end

    // ---------------- admission state machine ----------------
    pif_pkg::pif_state_t state;
    pif_pkg::pif_state_t next_state;
    logic [pif_pkg::PORT_W-1:0] f_port;
    logic f_tagged;
    logic f_sa_filt;
    logic f_da_filt;
    logic [pif_pkg::PORT_W-1:0] next_f_port;
    logic next_f_tagged;
    logic next_f_sa_filt;
    logic next_f_da_filt;
    logic next_lk_req;
    logic next_ready;
    logic next_dvalid;
    logic next_fwd;
    logic next_cpu;
    logic next_learn;
    logic next_viol;
    logic [1:0] ss;
    logic [1:0] sec;
    logic learn_dis;
    logic other_port;
    logic addr_viol;
    logic filt_viol;

    always_comb
    begin
        // config is read at decision time, so a frame sees the latest write
        ss = link_ctrl[f_port][pif_pkg::LC_SS_HI:pif_pkg::LC_SS_LO];
        sec = filt_ctrl[f_port][pif_pkg::FC_SEC_HI:pif_pkg::FC_SEC_LO];
        learn_dis = filt_ctrl[f_port][pif_pkg::FC_LEARN_DIS];
        other_port = lk_port_i != f_port;
        addr_viol = (lk_hit_i && lk_static_i && lk_addr_bit0_i && other_port)
            || (learn_dis && (!lk_hit_i || other_port));
        filt_viol = (filt_ctrl[f_port][pif_pkg::FC_UNTAG] && !f_tagged)
            || (filt_ctrl[f_port][pif_pkg::FC_TAG] && f_tagged)
            || f_sa_filt || f_da_filt;
        next_state = state;
        next_f_port = f_port;
        next_f_tagged = f_tagged;
        next_f_sa_filt = f_sa_filt;
        next_f_da_filt = f_da_filt;
        next_lk_req = 1'b0;
        next_dvalid = 1'b0;
        next_fwd = dec_forward_o;
        next_cpu = dec_to_cpu_o;
        next_learn = dec_learn_o;
        next_viol = dec_violation_o;
        unique case (state)
            pif_pkg::PIF_IDLE:
            begin
                if (frm_valid_i)
                begin
                    next_f_port = frm_port_i;
                    next_f_tagged = frm_tagged_i;
                    next_f_sa_filt = frm_sa_filt_i;
                    next_f_da_filt = frm_da_filt_i;
                    next_lk_req = 1'b1;
                    next_state = pif_pkg::PIF_LOOKUP;
                end
            end
            pif_pkg::PIF_LOOKUP:
            begin
                if (lk_valid_i)
                begin
                    next_dvalid = 1'b1;
                    next_learn = ss[1] && !learn_dis;
                    next_viol = (sec != pif_pkg::SEC_OFF) && (addr_viol || filt_viol);
                    next_fwd = 1'b0;
                    next_cpu = 1'b0;
                    if (!ss[0] || !ss[1])
                    begin
                        next_fwd = 1'b0;
                    end
                    else if (filt_viol)
                    begin
                        // with security off, filtered frames are simply discarded
                        next_cpu = sec[1];
                    end
                    else if (addr_viol && sec != pif_pkg::SEC_OFF)
                    begin
                        next_fwd = sec == pif_pkg::SEC_COPY_CPU;
                        next_cpu = sec[1];
                    end
                    else
                    begin
                        next_fwd = 1'b1;
                    end
                    next_state = pif_pkg::PIF_DONE;
                end
            end
            pif_pkg::PIF_DONE:
            begin
                next_state = pif_pkg::PIF_IDLE;
            end
        endcase
        next_ready = next_state == pif_pkg::PIF_IDLE;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            state <= pif_pkg::PIF_IDLE;
            f_port <= '0;
            f_tagged <= 1'b0;
            f_sa_filt <= 1'b0;
            f_da_filt <= 1'b0;
            frm_ready_o <= 1'b1;
            lk_req_o <= 1'b0;
            dec_valid_o <= 1'b0;
            dec_port_o <= '0;
            dec_forward_o <= 1'b0;
            dec_to_cpu_o <= 1'b0;
            dec_learn_o <= 1'b0;
            dec_violation_o <= 1'b0;
        end
        else
        begin
            state <= next_state;
            f_port <= next_f_port;
            f_tagged <= next_f_tagged;
            f_sa_filt <= next_f_sa_filt;
            f_da_filt <= next_f_da_filt;
            frm_ready_o <= next_ready;
            lk_req_o <= next_lk_req;
            dec_valid_o <= next_dvalid;
            dec_port_o <= f_port;
            dec_forward_o <= next_fwd;
            dec_to_cpu_o <= next_cpu;
            dec_learn_o <= next_learn;
            dec_violation_o <= next_viol;
        end
    end

    // ---------------- checks ----------------
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    a_stp_drop_all: assert property (
        dec_valid_o && !$past(ss[1] && ss[0]) |-> !dec_forward_o && !dec_to_cpu_o)
        else $error("frame passed while port not forwarding");
    a_learn_disable: assert property (
        dec_valid_o && $past(learn_dis) |-> !dec_learn_o)
        else $error("learned on a learning-disabled port");
    a_pause_asym: assert property (
        ##1 $past(cpu_serial_mii_i && link_ctrl[pif_pkg::CPU_PORT][5:0] == 6'h38)
        |-> cpu_pause_rx_en_o && !cpu_pause_tx_en_o)
        else $error("asymmetric flow control not honoured");
    a_fc_enable_bit: assert property (
        cpu_fc_en_o |-> $past(!link_ctrl[pif_pkg::CPU_PORT][pif_pkg::LC_FC_DIS]))
        else $error("flow control on while disabled");
    a_speed_select: assert property (
        ##1 cpu_speed_10_o == $past(link_ctrl[pif_pkg::CPU_PORT][pif_pkg::LC_SPEED10]))
        else $error("cpu port speed does not follow its bit");
    a_link_up_bit: assert property (
        cpu_link_up_o |-> $past(link_ctrl[pif_pkg::CPU_PORT][pif_pkg::LC_LINK_UP]))
        else $error("cpu mii link up while held down");
    a_untag_discard: assert property (
        state == pif_pkg::PIF_LOOKUP && lk_valid_i && sec == pif_pkg::SEC_OFF
        && filt_ctrl[f_port][pif_pkg::FC_UNTAG] && !f_tagged
        |=> dec_valid_o && !dec_forward_o && !dec_to_cpu_o)
        else $error("filtered untagged frame not discarded");
    a_sec_cpu_only: assert property (
        dec_valid_o && $past(ss == 2'h3 && !filt_viol && addr_viol && sec == pif_pkg::SEC_CPU_ONLY)
        |-> dec_to_cpu_o && !dec_forward_o)
        else $error("violating frame not sent only to cpu");
    a_filt_to_cpu: assert property (
        dec_valid_o && $past(ss == 2'h3 && filt_viol && sec[1]) |-> dec_to_cpu_o && !dec_forward_o)
        else $error("filter violation not redirected to cpu");
    a_decide_after_lookup: assert property (
        state == pif_pkg::PIF_LOOKUP && lk_valid_i |=> dec_valid_o)
        else $error("decision not one cycle after lookup answer");
    a_decide_needs_answer: assert property (
        dec_valid_o |-> $past(state == pif_pkg::PIF_LOOKUP && lk_valid_i))
        else $error("decision without a finished lookup");
endmodule
`default_nettype wire

// >>> dv/pif_lookup_model.sv
// address table model answering source address lookups
`timescale 1ns/100ps
`default_nettype none
module pif_lookup_model (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic lk_req_i,
    input wire logic [1:0] delay_i,
    input wire logic [6:0] res_i,
    output logic lk_valid_o,
    output logic [6:0] res_o
);
    logic [2:0] wait_cnt;
    logic busy;
    always @(posedge sys_clk_i)
    begin
        lk_valid_o <= 1'b0;
        // result lines churn outside the answer cycle, like a released bus
        res_o <= ~res_o;
        if (rst_i)
        begin
            busy <= 1'b0;
            res_o <= 7'h55;
        end
        else if (lk_req_i)
        begin
            busy <= 1'b1;
            wait_cnt <= {1'b0, delay_i};
        end
        else if (busy && wait_cnt != 3'h0)
            wait_cnt <= wait_cnt - 3'h1;
        else if (busy)
        begin
            busy <= 1'b0;
            lk_valid_o <= 1'b1;
            res_o <= res_i;
        end
    end
endmodule
`default_nettype wire

// >>> dv/port_ingress_filter_security_tb.sv
// self-checking bench for the ingress admission filter
`timescale 1ns/100ps
`default_nettype none
module port_ingress_filter_security_tb;
    localparam int SLOW = 600;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic reg_wr = 1'b0, reg_rd = 1'b0, serial_mii = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic link_up, speed10, fc_en, ptx, prx, frm_ready, lk_req, lk_valid;
    logic frm_valid = 1'b0, frm_tagged = 1'b0, frm_sa = 1'b0, frm_da = 1'b0;
    logic [3:0] frm_port = 4'h0, dec_port;
    logic [6:0] lk_res, m_res = 7'h00;
    logic [1:0] m_delay = 2'h0;
    logic dec_valid, dec_fwd, dec_cpu, dec_learn, dec_viol;
    logic [7:0] rate_tick;
    int failures = 0;
    int check_count = 0;

    initial forever #10 sys_clk_i = ~sys_clk_i;

    pif_ingress_filter #(.RATE_SLOW_CYC(SLOW)) DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_rdata_o(reg_rdata), .cpu_serial_mii_i(serial_mii), .cpu_link_up_o(link_up),
        .cpu_speed_10_o(speed10), .cpu_fc_en_o(fc_en), .cpu_pause_tx_en_o(ptx),
        .cpu_pause_rx_en_o(prx), .frm_valid_i(frm_valid), .frm_port_i(frm_port),
        .frm_tagged_i(frm_tagged), .frm_sa_filt_i(frm_sa), .frm_da_filt_i(frm_da),
        .frm_ready_o(frm_ready), .lk_req_o(lk_req), .lk_valid_i(lk_valid),
        .lk_hit_i(lk_res[6]), .lk_static_i(lk_res[5]), .lk_addr_bit0_i(lk_res[4]),
        .lk_port_i(lk_res[3:0]), .dec_valid_o(dec_valid), .dec_port_o(dec_port),
        .dec_forward_o(dec_fwd), .dec_to_cpu_o(dec_cpu), .dec_learn_o(dec_learn),
        .dec_violation_o(dec_viol), .rate_tick_o(rate_tick));

    pif_lookup_model lookup (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .lk_req_i(lk_req),
        .delay_i(m_delay), .res_i(m_res), .lk_valid_o(lk_valid), .res_o(lk_res));

    task automatic results;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk_i);
        reg_wr = 1'b0;
        @(negedge sys_clk_i);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk_i);
        reg_rd = 1'b0;
        d = reg_rdata;
        @(negedge sys_clk_i);
    endtask

    // one frame through lookup to decision; got = valid, port, fwd, cpu, learn, viol
    task automatic frame(input logic [3:0] p, input logic [2:0] fa, output logic [11:0] got);
        int n;
        n = 0;
        while (frm_ready !== 1'b1 && n < 20)
        begin
            @(negedge sys_clk_i);
            n++;
        end
        frm_port = p;
        {frm_tagged, frm_sa, frm_da} = fa;
        frm_valid = 1'b1;
        @(negedge sys_clk_i);
        frm_valid = 1'b0;
        n = 0;
        while (dec_valid !== 1'b1 && n < 20)
        begin
            @(negedge sys_clk_i);
            n++;
        end
        got = {3'h0, dec_valid, dec_port, dec_fwd, dec_cpu, dec_learn, dec_viol};
        @(negedge sys_clk_i);
    endtask

    task automatic wait_tick(output int n);
        n = 0;
        do
        begin
            @(negedge sys_clk_i);
            n++;
        end
        while (rate_tick[0] !== 1'b1 && n < 2000);
    endtask

    function automatic logic [3:0] exp_dec(input logic [1:0] ss, input logic [7:0] f,
        input logic [2:0] fa, input logic [6:0] lk, input logic [3:0] p);
        logic filt, addr, fwd, cpu;
        filt = (f[0] & !fa[2]) | (f[1] & fa[2]) | fa[1] | fa[0];
        addr = (lk[6] & lk[5] & lk[4] & lk[3:0] != p) | (f[2] & (!lk[6] | lk[3:0] != p));
        fwd = !filt & (!addr || f[7:6] == 2'h0 || f[7:6] == 2'h2);
        cpu = filt ? f[7] : addr & f[7];
        if (ss != 2'h3)
        begin
            fwd = 1'b0;
            cpu = 1'b0;
        end
        return {fwd, cpu, ss[1] & !f[2], (f[7:6] != 2'h0) & (addr | filt)};
    endfunction

    initial
    begin
        logic [7:0] d, f, v;
        logic [3:0] p;
        logic [11:0] got;
        logic [7:0] lv [6];
        int n;
        lv = '{8'hd8, 8'hf8, 8'hd9, 8'hdc, 8'hd0, 8'hfd};
        repeat (12) @(negedge sys_clk_i);
        rst_i = 1'b0;
        @(negedge sys_clk_i);
        wr(8'h14, 8'hff);
        for (int a = 0; a <= 8'h14; a++)
        begin
            rd(8'(a), d);
            check({4'h0, d}, a >= 8'h14 ? 12'h0 : a[0] ? 12'h0 : 12'h0c0);
        end
        $display("register reset test done");
        serial_mii = 1'b1;
        foreach (lv[k])
        begin
            v = lv[k];
            wr(8'h10, v); // duplex zero, bit 4 one
            repeat (2) @(negedge sys_clk_i);
            check({7'h0, link_up, speed10, fc_en, ptx, prx},
                {7'h0, v[3], v[2], v[3] & !v[0], v[3] & !v[0] & !v[5], v[3] & !v[0]});
        end
        // serial-only mode: link bit still set, but no mii to bring up
        serial_mii = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        check({9'h0, link_up, fc_en, prx}, 12'h000);
        $display("cpu link test done");
        for (int j = 0; j < 8; j++)
        begin
            f = {5'h0, j[2], 2'h0};
            wr(8'h06, {j[1:0], 6'h10});
            wr(8'h07, f);
            m_res = 7'h43;
            frame(4'h3, 3'h0, got);
            check(got, {4'h1, 4'h3, exp_dec(j[1:0], f, 3'h0, 7'h43, 4'h3)});
        end
        wr(8'h06, 8'hc0);
        wr(8'h07, 8'h00);
        $display("spanning test done");
        for (int i = 0; i < 4096; i++)
        begin
            p = 4'(i % 10);
            f = {i[1:0], 3'h0, i[4:2]}; // bits 5 and 4 written zero
            m_res = {i[10:8], i[11] ? p : 4'((i % 10 + 1) % 10)};
            m_delay = 2'(i % 3);
            wr({3'h0, p, 1'b1}, f);
            frame(p, i[7:5], got);
            check(got, {4'h1, p, exp_dec(2'h3, f, i[7:5], m_res, p)});
        end
        $display("admission test done");
        wr(8'h01, 8'h00);
        for (int k = 0; k < 2; k++)
        begin
            wait_tick(n);
            wait_tick(n);
            check(12'(n), k ? 12'(SLOW) : 12'(pif_pkg::RATE_FAST_CYC));
            // all rate ports share the fast rate and one reset, so tick together
            if (k == 0)
                check({4'h0, rate_tick}, 12'h0ff);
            wr(8'h01, 8'h08);
        end
        $display("rate tick test done");
        results();
    end

    // the whole run needs about 36000 cycles
    initial
    begin
        repeat (90000) @(posedge sys_clk_i);
        failures++;
        results();
    end
endmodule
`default_nettype wire
